// ===== verilog/dma_packet_stream_framing_defines.vh
/*
  Constants of the packet stream framer: register offsets, field positions,
  reset values and framing counts. Assumes a 32-bit word-addressed
  descriptor and buffer memory inside the block.
*/
`ifndef DMA_PACKET_STREAM_FRAMING_DEFINES_VH
`define DMA_PACKET_STREAM_FRAMING_DEFINES_VH

`define R_TX_CTRL    10'h000
`define R_TX_CUR     10'h001
`define R_TX_TAIL    10'h002
`define R_TX_STAT    10'h003
`define R_RX_CTRL    10'h004
`define R_RX_CUR     10'h005
`define R_RX_TAIL    10'h006
`define R_RX_STAT    10'h007
`define R_FTR_HI     7'h01
`define MEM_TX_SEL   2'h1
`define MEM_RX_SEL   2'h2

`define CTRL_TPE     0
`define CTRL_RESET   1'b1

`define ST_BUSY      0
`define ST_DONE      1
`define ST_SOP       2
`define ST_EOP       3

`define D_NEXT       3'h0
`define D_BUF        3'h1
`define D_LEN        3'h2
`define D_CTL        3'h3
`define DC_STOP      0
`define DC_DONE      1
`define DC_SOP       2
`define DC_EOP       3

`define HDR_LAST     3'h7
`define FTR_LAST     3'h7
`define WORD_BYTES   16'h0004

`endif

// ===== verilog/dma_packet_stream_framing.v
/*
  Transmit and receive packet framer of a descriptor-driven DMA channel
  pair, with descriptor and buffer memories and a plain register port.
  Assumes the stream partner is synchronous to clk_i and that software
  loads descriptors before starting a channel.
*/
`include "dma_packet_stream_framing_defines.vh"

module dma_packet_stream_framing #(
  parameter AW = 8
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [11:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output reg  [31:0] tx_data_o,
  output reg  [3:0]  tx_rem_o,
  output reg         tx_sof_n_o,
  output reg         tx_sop_n_o,
  output reg         tx_eop_n_o,
  output reg         tx_eof_n_o,
  output reg         tx_src_rdy_n_o,
  input  wire        tx_dst_rdy_n_i,
  input  wire [31:0] rx_data_i,
  input  wire [3:0]  rx_rem_i,
  input  wire        rx_sof_n_i,
  input  wire        rx_sop_n_i,
  input  wire        rx_eop_n_i,
  input  wire        rx_eof_n_i,
  input  wire        rx_src_rdy_n_i,
  output reg         rx_dst_rdy_n_o
);

  localparam T_IDLE  = 6'b000001;
  localparam T_FETCH = 6'b000010;
  localparam T_HDR   = 6'b000100;
  localparam T_PAY   = 6'b001000;
  localparam T_EOF   = 6'b010000;
  localparam T_NEXT  = 6'b100000;
  localparam R_IDLE  = 5'b00001;
  localparam R_FETCH = 5'b00010;
  localparam R_RUN   = 5'b00100;
  localparam R_FTR   = 5'b01000;
  localparam R_NEXT  = 5'b10000;

  reg [31:0]   tx_mem [0:(1<<AW)-1];
  reg [31:0]   rx_mem [0:(1<<AW)-1];
  reg [31:0]   ftr_reg [0:7];

  reg          tx_tpe_reg;
  reg [AW-1:0] tx_cur_reg;
  reg [AW-1:0] tx_tail_reg;
  reg          tx_busy_reg;
  reg          tx_done_reg;
  reg [5:0]    tx_state_reg;
  reg [AW-1:0] tx_buf_reg;
  reg [15:0]   tx_len_reg;
  reg [31:0]   tx_ctl_reg;
  reg [2:0]    tx_idx_reg;
  reg          tx_first_reg;

  reg          rx_tpe_reg;
  reg [AW-1:0] rx_cur_reg;
  reg [AW-1:0] rx_tail_reg;
  reg          rx_busy_reg;
  reg          rx_done_reg;
  reg          rx_sop_reg;
  reg          rx_eop_reg;
  reg [4:0]    rx_state_reg;
  reg [4:0]    rx_state_next;
  reg [AW-1:0] rx_buf_reg;
  reg [15:0]   rx_len_reg;
  reg [2:0]    rx_fidx_reg;
  reg          rx_in_pay_reg;
  reg          rx_dsop_reg;
  reg          rx_deop_reg;

  function [AW-1:0] at;
    input [AW-1:0] base;
    input [2:0]    off;
    begin
      at = base + {{(AW-3){1'b0}}, off};
    end
  endfunction

  // Active-low byte mask for n valid low-lane bytes, zero meaning four
  function [3:0] rem_of;
    input [2:0] n;
    integer i;
    begin
      rem_of = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        rem_of[i] = (n != 3'h0) && (i >= n);
      end
    end
  endfunction

  wire [9:0] widx   = addr_i[11:2];
  wire       reg_sel = (addr_i[11:6] == 6'h00);
  wire       sw_reg_wr = wr_i && reg_sel;
  wire       tx_mem_wr = wr_i && (addr_i[11:10] == `MEM_TX_SEL);
  wire       rx_mem_wr = wr_i && (addr_i[11:10] == `MEM_RX_SEL);
  wire [AW-1:0] maddr = addr_i[AW+1:2];

  // Transmit engine
  wire tx_beat = !tx_src_rdy_n_o && !tx_dst_rdy_n_i;
  // Output word is replaced only once taken, so stalls hold it
  wire tx_load = tx_src_rdy_n_o || tx_beat;
  wire tx_tail_hit = tx_tpe_reg && (tx_cur_reg == tx_tail_reg);
  wire tx_last_word = (tx_len_reg <= `WORD_BYTES);
  wire tx_pkt_end = tx_last_word && tx_ctl_reg[`DC_EOP];
  wire tx_wb = tx_state_reg[3] && tx_load && tx_last_word;
  wire tx_start = !tx_busy_reg && sw_reg_wr &&
                  ((!tx_tpe_reg && widx == `R_TX_CUR) ||
                   (tx_tpe_reg && widx == `R_TX_TAIL));

  always @(posedge clk_i) begin
    if (tx_wb) begin
      tx_mem[at(tx_cur_reg, `D_CTL)] <= tx_ctl_reg | (32'h1 << `DC_DONE);
    end else if (tx_mem_wr) begin
      tx_mem[maddr] <= wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_tpe_reg     <= `CTRL_RESET;
      tx_cur_reg     <= {AW{1'b0}};
      tx_tail_reg    <= {AW{1'b0}};
      tx_busy_reg    <= 1'b0;
      tx_done_reg    <= 1'b0;
      tx_state_reg   <= T_IDLE;
      tx_buf_reg     <= {AW{1'b0}};
      tx_len_reg     <= 16'h0000;
      tx_ctl_reg     <= 32'h00000000;
      tx_idx_reg     <= 3'h0;
      tx_first_reg   <= 1'b0;
      tx_data_o      <= 32'h00000000;
      tx_rem_o       <= 4'h0;
      tx_sof_n_o     <= 1'b1;
      tx_sop_n_o     <= 1'b1;
      tx_eop_n_o     <= 1'b1;
      tx_eof_n_o     <= 1'b1;
      tx_src_rdy_n_o <= 1'b1;
    end else begin
      if (tx_beat) begin
        tx_src_rdy_n_o <= 1'b1;
      end
      // Busy channel takes only the tail and status writes; control and current are dropped
      if (sw_reg_wr && widx == `R_TX_TAIL) begin
        tx_tail_reg <= wdata_i[AW-1:0];
      end
      if (sw_reg_wr && !tx_busy_reg) begin
        if (widx == `R_TX_CTRL) begin
          tx_tpe_reg <= wdata_i[`CTRL_TPE];
        end
        if (widx == `R_TX_CUR) begin
          tx_cur_reg <= wdata_i[AW-1:0];
        end
      end
      if (sw_reg_wr && widx == `R_TX_STAT && wdata_i[`ST_DONE]) begin
        tx_done_reg <= 1'b0;
      end
      if (tx_start) begin
        tx_busy_reg <= 1'b1;
      end
      case (tx_state_reg)
        T_IDLE: begin
          if (tx_start) begin
            tx_state_reg <= T_FETCH;
          end
        end
        T_FETCH: begin
          tx_buf_reg   <= tx_mem[at(tx_cur_reg, `D_BUF)][AW-1:0];
          tx_len_reg   <= tx_mem[at(tx_cur_reg, `D_LEN)][15:0];
          tx_ctl_reg   <= tx_mem[at(tx_cur_reg, `D_CTL)];
          tx_idx_reg   <= 3'h0;
          // Only a start descriptor opens a frame with a header
          if (tx_mem[at(tx_cur_reg, `D_CTL)][`DC_SOP]) begin
            tx_state_reg <= T_HDR;
          end else begin
            tx_state_reg <= T_PAY;
          end
        end
        T_HDR: begin
          if (tx_load) begin
            tx_data_o      <= tx_mem[at(tx_cur_reg, tx_idx_reg)];
            tx_sof_n_o     <= (tx_idx_reg != 3'h0);
            tx_sop_n_o     <= 1'b1;
            tx_eop_n_o     <= 1'b1;
            tx_eof_n_o     <= 1'b1;
            tx_rem_o       <= 4'h0;
            tx_src_rdy_n_o <= 1'b0;
            tx_idx_reg     <= tx_idx_reg + 3'h1;
            tx_first_reg   <= 1'b1;
            if (tx_idx_reg == `HDR_LAST) begin
              tx_state_reg <= T_PAY;
            end
          end
        end
        T_PAY: begin
          if (tx_load) begin
            // Buffers of chained descriptors follow back to back
            tx_data_o      <= tx_mem[tx_buf_reg];
            tx_sof_n_o     <= 1'b1;
            tx_sop_n_o     <= !tx_first_reg;
            tx_eop_n_o     <= !tx_pkt_end;
            tx_eof_n_o     <= 1'b1;
            tx_src_rdy_n_o <= 1'b0;
            // Masked-off lanes are the far side's to ignore
            tx_rem_o       <= tx_pkt_end ?
                              rem_of(tx_len_reg[2:0]) : 4'h0;
            tx_first_reg   <= 1'b0;
            tx_buf_reg     <= tx_buf_reg + {{(AW-1){1'b0}}, 1'b1};
            tx_len_reg     <= tx_last_word ? 16'h0000 :
                              tx_len_reg - `WORD_BYTES;
            if (tx_last_word) begin
              tx_done_reg  <= 1'b1;
              tx_state_reg <= tx_pkt_end ? T_EOF : T_NEXT;
            end
          end
        end
        T_EOF: begin
          // No footer on transmit, so frame end takes the next beat
          if (tx_load) begin
            tx_data_o      <= 32'h00000000;
            tx_sop_n_o     <= 1'b1;
            tx_eop_n_o     <= 1'b1;
            tx_eof_n_o     <= 1'b0;
            tx_rem_o       <= 4'h0;
            tx_src_rdy_n_o <= 1'b0;
            tx_state_reg   <= T_NEXT;
          end
        end
        T_NEXT: begin
          tx_cur_reg <= tx_mem[at(tx_cur_reg, `D_NEXT)][AW-1:0];
          if (tx_ctl_reg[`DC_STOP] || tx_tail_hit) begin
            tx_busy_reg  <= 1'b0;
            tx_state_reg <= T_IDLE;
          end else begin
            tx_state_reg <= T_FETCH;
          end
        end
        default: begin
          tx_state_reg <= T_IDLE;
        end
      endcase
    end
  end

  // Receive engine
  wire rx_beat = !rx_src_rdy_n_i && !rx_dst_rdy_n_o;
  wire rx_tail_hit = rx_tpe_reg && (rx_cur_reg == rx_tail_reg);
  wire rx_pay = rx_beat && rx_state_reg[2] && (rx_in_pay_reg || !rx_sop_n_i);
  wire rx_eop = rx_pay && !rx_eop_n_i;
  wire rx_full = rx_pay && (rx_len_reg <= `WORD_BYTES);
  wire rx_wb = rx_eop || rx_full;
  wire rx_start = !rx_busy_reg && sw_reg_wr &&
                  ((!rx_tpe_reg && widx == `R_RX_CUR) ||
                   (rx_tpe_reg && widx == `R_RX_TAIL));
  reg  [31:0] rx_keep;
  integer k;

  // Footer lanes of the end word are zeroed, never stored as payload
  always @* begin
    rx_keep = 32'h00000000;
    for (k = 0; k < 4; k = k + 1) begin
      rx_keep[k*8 +: 8] = (rx_eop_n_i || !rx_rem_i[k]) ? 8'hFF : 8'h00;
    end
  end

  // Descriptor status copy goes to a spare word to avoid a second port
  always @(posedge clk_i) begin
    if (rx_state_reg[4]) begin
      rx_mem[at(rx_cur_reg, 3'h4)] <= {28'h0000000, rx_deop_reg,
                                       rx_dsop_reg, 2'h2};
    end else if (rx_pay) begin
      rx_mem[rx_buf_reg] <= rx_data_i & rx_keep;
    end else if (rx_mem_wr) begin
      rx_mem[maddr] <= wdata_i;
    end
  end

  always @* begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      R_IDLE:  rx_state_next = rx_start ? R_FETCH : R_IDLE;
      R_FETCH: rx_state_next = R_RUN;
      R_RUN: begin
        if (rx_eop) begin
          rx_state_next = R_FTR;
        end else if (rx_full) begin
          rx_state_next = R_NEXT;
        end
      end
      R_FTR: begin
        if (rx_beat && (!rx_eof_n_i || rx_fidx_reg == `FTR_LAST)) begin
          rx_state_next = R_NEXT;
        end
      end
      R_NEXT: begin
        rx_state_next = (rx_deop_reg || rx_tail_hit) ? R_IDLE : R_FETCH;
      end
      default: rx_state_next = R_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_tpe_reg     <= `CTRL_RESET;
      rx_cur_reg     <= {AW{1'b0}};
      rx_tail_reg    <= {AW{1'b0}};
      rx_busy_reg    <= 1'b0;
      rx_done_reg    <= 1'b0;
      rx_sop_reg     <= 1'b0;
      rx_eop_reg     <= 1'b0;
      rx_state_reg   <= R_IDLE;
      rx_buf_reg     <= {AW{1'b0}};
      rx_len_reg     <= 16'h0000;
      rx_fidx_reg    <= 3'h0;
      rx_in_pay_reg  <= 1'b0;
      rx_dsop_reg    <= 1'b0;
      rx_deop_reg    <= 1'b0;
      rx_dst_rdy_n_o <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      // Ready only where a beat lands in buffer or footer space
      rx_dst_rdy_n_o <= !(rx_state_next[2] || rx_state_next[3]);
      if (sw_reg_wr && widx == `R_RX_TAIL) begin
        rx_tail_reg <= wdata_i[AW-1:0];
      end
      if (sw_reg_wr && !rx_busy_reg) begin
        if (widx == `R_RX_CTRL) begin
          rx_tpe_reg <= wdata_i[`CTRL_TPE];
        end
        if (widx == `R_RX_CUR) begin
          rx_cur_reg <= wdata_i[AW-1:0];
        end
      end
      // Status clear by writing one; a set in the same cycle wins
      if (sw_reg_wr && widx == `R_RX_STAT) begin
        rx_done_reg <= rx_done_reg & !wdata_i[`ST_DONE];
        rx_sop_reg  <= rx_sop_reg & !wdata_i[`ST_SOP];
        rx_eop_reg  <= rx_eop_reg & !wdata_i[`ST_EOP];
      end
      if (rx_start) begin
        rx_busy_reg <= 1'b1;
      end
      if (rx_state_reg[1]) begin
        rx_buf_reg  <= rx_mem[at(rx_cur_reg, `D_BUF)][AW-1:0];
        rx_len_reg  <= rx_mem[at(rx_cur_reg, `D_LEN)][15:0];
        rx_dsop_reg <= 1'b0;
        rx_deop_reg <= 1'b0;
      end
      // Header beats fall through untouched
      if (rx_pay) begin
        rx_in_pay_reg <= rx_eop_n_i;
        rx_buf_reg    <= rx_buf_reg + {{(AW-1){1'b0}}, 1'b1};
        rx_len_reg    <= (rx_len_reg <= `WORD_BYTES) ? 16'h0000 :
                         rx_len_reg - `WORD_BYTES;
        if (!rx_sop_n_i) begin
          rx_sop_reg  <= 1'b1;
          rx_dsop_reg <= 1'b1;
        end
        if (!rx_eop_n_i) begin
          rx_eop_reg  <= 1'b1;
          rx_deop_reg <= 1'b1;
        end
      end
      if (rx_wb) begin
        rx_done_reg <= 1'b1;
      end
      if (rx_state_reg[2] && rx_eop) begin
        rx_fidx_reg <= 3'h0;
      end
      if (rx_state_reg[3] && rx_beat) begin
        ftr_reg[rx_fidx_reg] <= rx_data_i;
        rx_fidx_reg          <= rx_fidx_reg + 3'h1;
      end
      if (rx_state_reg[4]) begin
        rx_cur_reg <= rx_mem[at(rx_cur_reg, `D_NEXT)][AW-1:0];
        if (rx_state_next[0]) begin
          rx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Register read port; data stand in the cycle after the strobe
  always @(posedge clk_i) begin
    if (!rst_n_i || !rd_i) begin
      rdata_o <= 32'h00000000;
    end else if (addr_i[11:10] == `MEM_TX_SEL) begin
      rdata_o <= tx_mem[maddr];
    end else if (addr_i[11:10] == `MEM_RX_SEL) begin
      rdata_o <= rx_mem[maddr];
    end else if (addr_i[11:5] == `R_FTR_HI) begin
      rdata_o <= ftr_reg[addr_i[4:2]];
    end else begin
      case (widx)
        `R_TX_CTRL: rdata_o <= {31'h00000000, tx_tpe_reg};
        `R_TX_CUR:  rdata_o <= {{(32-AW){1'b0}}, tx_cur_reg};
        `R_TX_TAIL: rdata_o <= {{(32-AW){1'b0}}, tx_tail_reg};
        `R_TX_STAT: rdata_o <= {30'h00000000, tx_done_reg, tx_busy_reg};
        `R_RX_CTRL: rdata_o <= {31'h00000000, rx_tpe_reg};
        `R_RX_CUR:  rdata_o <= {{(32-AW){1'b0}}, rx_cur_reg};
        `R_RX_TAIL: rdata_o <= {{(32-AW){1'b0}}, rx_tail_reg};
        `R_RX_STAT: rdata_o <= {28'h0000000, rx_eop_reg, rx_sop_reg,
                                rx_done_reg, rx_busy_reg};
        default:    rdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule // dma_packet_stream_framing

// ===== dv/dma_packet_stream_framing_props.sv
/*
  Port checks of the packet stream framer.
  Assumes one clock and the synchronous active-low reset.
*/
module framing_props (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [31:0] tx_data_o,
  input wire logic [3:0]  tx_rem_o,
  input wire logic        tx_sof_n_o,
  input wire logic        tx_sop_n_o,
  input wire logic        tx_eop_n_o,
  input wire logic        tx_eof_n_o,
  input wire logic        tx_src_rdy_n_o,
  input wire logic        tx_dst_rdy_n_i,
  input wire logic        rx_eof_n_i,
  input wire logic        rx_src_rdy_n_i,
  input wire logic        rx_dst_rdy_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tx_beat;
  logic [3:0] hdr_cnt_reg;
  assign tx_beat = !tx_src_rdy_n_o && !tx_dst_rdy_n_i;
  // Header beats seen since frame start; stalls do not count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      hdr_cnt_reg <= 4'h0;
    else if (tx_beat && !tx_sof_n_o)
      hdr_cnt_reg <= 4'h1;
    else if (tx_beat && hdr_cnt_reg != 4'h0 && hdr_cnt_reg != 4'h8)
      hdr_cnt_reg <= hdr_cnt_reg + 4'h1;
    else if (tx_beat && !tx_sop_n_o)
      hdr_cnt_reg <= 4'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_tx_hdr_len: assert property (tx_beat && !tx_sop_n_o |-> hdr_cnt_reg == 4'h8)
    else $error("payload start not after eight header words");
  a_tx_eof_next: assert property (tx_beat && !tx_eop_n_o |=> !tx_src_rdy_n_o && !tx_eof_n_o)
    else $error("frame end missing after payload end");
  a_tx_eof_empty: assert property (!tx_src_rdy_n_o && !tx_eof_n_o |-> tx_data_o == 32'h0 && tx_eop_n_o && tx_sop_n_o)
    else $error("frame end word carries data");
  a_tx_rem_zero: assert property (!tx_src_rdy_n_o && tx_eop_n_o |-> tx_rem_o == 4'h0)
    else $error("byte mask set off the last word");
  a_tx_hold_stall: assert property (!tx_src_rdy_n_o && tx_dst_rdy_n_i |=> $stable(tx_data_o) && $stable(tx_rem_o) && $stable({tx_sof_n_o, tx_sop_n_o, tx_eop_n_o}))
    else $error("word changed while stalled");
  a_tx_sof_alone: assert property (!tx_src_rdy_n_o && !tx_sof_n_o |-> tx_sop_n_o && tx_eop_n_o && tx_eof_n_o)
    else $error("frame start shares a word with other markers");
  a_rx_footer_fetch: assert property (!rx_src_rdy_n_i && !rx_dst_rdy_n_o && !rx_eof_n_i |=> rx_dst_rdy_n_o)
    else $error("receive ready held after frame end");
  a_rd_data_quiet: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data without a read");
endmodule // framing_props

// ===== dv/stream_peer.sv
/*
  Far-side stream logic: sink of the transmit stream, source of the receive
  stream. Assumes the bench fills rx_q and drains tx_got.
*/
module stream_peer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] tx_data_i,
  input  wire logic [3:0]  tx_rem_i,
  input  wire logic [3:0]  tx_mark_n_i,
  input  wire logic        tx_src_rdy_n_i,
  output logic             tx_dst_rdy_n_o,
  output logic [31:0]      rx_data_o,
  output logic [3:0]       rx_rem_o,
  output logic [3:0]       rx_mark_n_o,
  output logic             rx_src_rdy_n_o,
  input  wire logic        rx_dst_rdy_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] tx_got[$];
  logic [39:0] rx_q[$];
  logic        stall_en;
  logic        rx_beat;
  int          seed;
  initial begin
    stall_en = 1'b0;
    seed = 32'hc82b6e2d;
    tx_dst_rdy_n_o = 1'b1;
    rx_src_rdy_n_o = 1'b1;
    rx_data_o = 32'h0;
    rx_rem_o = 4'h0;
    rx_mark_n_o = 4'hF;
  end
  always @(posedge clk_i) begin
    rx_beat = !rx_src_rdy_n_o && !rx_dst_rdy_n_i;
    if (!tx_src_rdy_n_i && !tx_dst_rdy_n_o)
      tx_got.push_back({tx_mark_n_i, tx_rem_i, tx_data_i});
    tx_dst_rdy_n_o <= !rst_n_i || (stall_en && $random(seed) % 4 == 0);
    if (rx_beat)
      void'(rx_q.pop_front());
    // A presented word is held until taken; stalls only between words
    if (rx_src_rdy_n_o || rx_beat) begin
      if (rx_q.size() != 0 && !(stall_en && $random(seed) % 3 == 0)) begin
        {rx_mark_n_o, rx_rem_o, rx_data_o} <= rx_q[0];
        rx_src_rdy_n_o <= 1'b0;
      end else begin
        rx_src_rdy_n_o <= 1'b1;
        rx_mark_n_o <= 4'hF;
        rx_data_o <= ~rx_data_o;
      end
    end
  end
endmodule // stream_peer

// ===== dv/testbench.sv
/*
  Self-checking bench of the packet stream framer with a far-side peer.
  Assumes the framer's register map and descriptor layout.
*/
`include "dma_packet_stream_framing_defines.vh"
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_n_i, wr_i, rd_i;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o, tx_data_o, rx_data;
  logic [3:0]  tx_rem_o, rx_rem, rx_mark_n;
  logic        tx_sof_n_o, tx_sop_n_o, tx_eop_n_o, tx_eof_n_o;
  logic        tx_src_rdy_n_o, tx_dst_rdy_n, rx_src_rdy_n, rx_dst_rdy_n_o;
  logic [31:0] txm [0:255];
  logic [31:0] d;
  int          bad_count, samples_checked, seed;
  dma_packet_stream_framing i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_data_o(tx_data_o),
    .tx_rem_o(tx_rem_o), .tx_sof_n_o(tx_sof_n_o), .tx_sop_n_o(tx_sop_n_o),
    .tx_eop_n_o(tx_eop_n_o), .tx_eof_n_o(tx_eof_n_o),
    .tx_src_rdy_n_o(tx_src_rdy_n_o), .tx_dst_rdy_n_i(tx_dst_rdy_n),
    .rx_data_i(rx_data), .rx_rem_i(rx_rem), .rx_sof_n_i(rx_mark_n[3]),
    .rx_sop_n_i(rx_mark_n[2]), .rx_eop_n_i(rx_mark_n[1]),
    .rx_eof_n_i(rx_mark_n[0]), .rx_src_rdy_n_i(rx_src_rdy_n),
    .rx_dst_rdy_n_o(rx_dst_rdy_n_o));
  stream_peer i_peer (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_data_i(tx_data_o),
    .tx_rem_i(tx_rem_o),
    .tx_mark_n_i({tx_sof_n_o, tx_sop_n_o, tx_eop_n_o, tx_eof_n_o}),
    .tx_src_rdy_n_i(tx_src_rdy_n_o), .tx_dst_rdy_n_o(tx_dst_rdy_n),
    .rx_data_o(rx_data), .rx_rem_o(rx_rem), .rx_mark_n_o(rx_mark_n),
    .rx_src_rdy_n_o(rx_src_rdy_n), .rx_dst_rdy_n_i(rx_dst_rdy_n_o));
  always #2.5 clk_i = ~clk_i;
  function automatic logic [11:0] ra(input logic [9:0] r);
    return {r, 2'b00};
  endfunction
  function automatic logic [3:0] rem_of(input int len);
    return 4'hF << ((len % 4 == 0) ? 4 : len % 4);
  endfunction
  function automatic logic [31:0] keep(input logic [31:0] v, input logic [3:0] r);
    for (int i = 0; i < 4; i++)
      if (r[i])
        v[8*i +: 8] = 8'h00;
    return v;
  endfunction
  task automatic print_verdict();
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic put(input int w, input logic [31:0] v);
    txm[w] = v;
    wr(12'h400 + 12'(w * 4), v);
  endtask
  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_q(input logic tx, input int n);
    int k;
    k = 0;
    while ((tx ? i_peer.tx_got.size() < n : i_peer.rx_q.size() > 0) && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 3000) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic tx_run(input logic legacy, input logic chain);
    int la, lb, nl, w;
    logic [39:0] g;
    logic [3:0] r;
    logic [31:0] pw[$];
    la = chain ? 8 : 1 + ($random(seed) & 15);
    lb = 1 + ($random(seed) & 7);
    nl = chain ? lb : la;
    put(0, chain ? 40 : 0);
    put(1, 16);
    put(2, la);
    put(3, chain ? 32'h4 : 32'hD);
    for (w = 4; w < 8; w++)
      put(w, $random(seed));
    for (w = 0; w < (la + 3) / 4; w++) begin
      put(16 + w, $random(seed));
      pw.push_back(txm[16 + w]);
    end
    if (chain) begin
      put(40, 0);
      put(41, 56);
      put(42, lb);
      put(43, 32'h9);
      for (w = 0; w < (lb + 3) / 4; w++) begin
        put(56 + w, $random(seed));
        pw.push_back(txm[56 + w]);
      end
    end
    if (legacy) begin
      wr(ra(`R_TX_CTRL), 0);
      wr(ra(`R_TX_TAIL), 0);
      repeat (20) @(posedge clk_i);
      `CHK(i_peer.tx_got.size(), 0)
      wr(ra(`R_TX_CUR), 0);
      wr(ra(`R_TX_CTRL), 1);
    end else begin
      wr(ra(`R_TX_CTRL), 1);
      wr(ra(`R_TX_CUR), 0);
      wr(ra(`R_TX_TAIL), chain ? 40 : 0);
    end
    wait_q(1'b1, 9 + pw.size());
    for (w = 0; w < 8; w++) begin
      g = i_peer.tx_got.pop_front();
      `CHK(g, {w == 0 ? 4'h7 : 4'hF, 4'h0, txm[w]})
    end
    for (w = 0; w < pw.size(); w++) begin
      g = i_peer.tx_got.pop_front();
      r = (w == pw.size() - 1) ? rem_of(nl) : 4'h0;
      `CHK({g[39:32], keep(g[31:0], g[35:32])}, {1'b1, w != 0, w != pw.size() - 1, 1'b1, r, keep(pw[w], r)})
    end
    g = i_peer.tx_got.pop_front();
    `CHK(g[39:32], 8'hE0)
    repeat (4) @(posedge clk_i);
    rd(ra(`R_TX_STAT), d);
    `CHK(d[1:0], 2'b10)
    wr(ra(`R_TX_STAT), 32'h2);
    if (legacy) begin
      rd(ra(`R_TX_CTRL), d);
      `CHK(d[0], 1'b0)
    end
  endtask
  task automatic rx_run();
    int n, k;
    logic [3:0] r;
    logic [31:0] pw[4];
    logic [31:0] ft[8];
    n = 1 + ($random(seed) & 3);
    r = rem_of(1 + ($random(seed) & 3));
    wr(12'h800, 0);
    wr(12'h804, 16);
    wr(12'h808, 32);
    wr(12'h80C, 0);
    wr(ra(`R_RX_CTRL), 1);
    wr(ra(`R_RX_TAIL), 0);
    i_peer.rx_q.push_back({4'h7, 4'h0, 32'hDEADBEEF});
    for (k = 0; k < n; k++) begin
      pw[k] = $random(seed);
      i_peer.rx_q.push_back({1'b1, k != 0, k != n - 1, 1'b1, k == n - 1 ? r : 4'h0, pw[k]});
    end
    for (k = 0; k < 8; k++) begin
      ft[k] = $random(seed);
      i_peer.rx_q.push_back({3'h7, k != 7, 4'h0, ft[k]});
    end
    wait_q(1'b0, 0);
    repeat (8) @(posedge clk_i);
    for (k = 0; k < n; k++) begin
      rd(12'h840 + 12'(k * 4), d);
      `CHK(d, k == n - 1 ? keep(pw[k], r) : pw[k])
    end
    for (k = 0; k < 8; k++) begin
      rd(12'h020 + 12'(k * 4), d);
      `CHK(d, ft[k])
    end
    rd(12'h810, d);
    `CHK(d[3:0], 4'hE)
    rd(ra(`R_RX_STAT), d);
    `CHK(d[3:0], 4'hE)
    wr(ra(`R_RX_STAT), 32'hE);
  endtask
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    addr_i = 12'h000;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    seed = 32'hc82b6e2d;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ra(`R_TX_CTRL), d);
    `CHK(d, 32'h1)
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, d);
    `CHK(d, 32'h0)
    `CHK(rx_dst_rdy_n_o, 1'b1)
    for (int i = 0; i < 6; i++) begin
      i_peer.stall_en = i[0];
      tx_run(i == 4, i >= 2);
      rx_run();
    end
    print_verdict();
  end
endmodule // testbench
bind dma_packet_stream_framing framing_props i_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .tx_data_o(tx_data_o), .tx_rem_o(tx_rem_o), .tx_sof_n_o(tx_sof_n_o),
  .tx_sop_n_o(tx_sop_n_o), .tx_eop_n_o(tx_eop_n_o),
  .tx_eof_n_o(tx_eof_n_o), .tx_src_rdy_n_o(tx_src_rdy_n_o),
  .tx_dst_rdy_n_i(tx_dst_rdy_n_i), .rx_eof_n_i(rx_eof_n_i),
  .rx_src_rdy_n_i(rx_src_rdy_n_i), .rx_dst_rdy_n_o(rx_dst_rdy_n_o));
